// *** design/pbw_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbw_debounce
  import pbw_pkg::*;
#(
  parameter int unsigned CYCLES = PBW_DEBOUNCE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin_n,
  output logic sync_level,
  output logic stable_level
);

  logic meta_reg;
  logic sync_reg;
  logic stable_reg;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic differ;
  logic settled;

  // ****************************************
  // Level must hold unchanged for CYCLES
  // ****************************************
  assign differ = sync_reg != stable_reg;
  assign settled = differ && (count_reg >= 32'(CYCLES - 1));
  assign count_next = (differ && !settled) ? count_reg + 32'h0000_0001 : 32'h0000_0000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      stable_reg <= 1'b1;
      count_reg <= 32'h0000_0000;
    end else begin
      meta_reg <= pin_n;
      sync_reg <= meta_reg;
      count_reg <= count_next;
      if (settled) begin
        stable_reg <= sync_reg;
      end
    end
  end

  assign sync_level = sync_reg;
  assign stable_level = stable_reg;

endmodule // pbw_debounce
`default_nettype wire

// *** design/pbw_pkg.sv ***
`default_nettype none
package pbw_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned PBW_CLK_PERIOD_NS = 10;
  localparam int unsigned PBW_NS_PER_MS = 1_000_000;
  localparam int unsigned PBW_DEBOUNCE_MS = 40;
  localparam int unsigned PBW_SLOW_MS = 250;
  localparam int unsigned PBW_FAST_MS = 50;
  localparam int unsigned PBW_LONG_PRESS_MS = 1000;
  localparam int unsigned PBW_DEBOUNCE_CYCLES = PBW_DEBOUNCE_MS * PBW_NS_PER_MS / PBW_CLK_PERIOD_NS;
  localparam int unsigned PBW_SLOW_CYCLES = PBW_SLOW_MS * PBW_NS_PER_MS / PBW_CLK_PERIOD_NS;
  localparam int unsigned PBW_FAST_CYCLES = PBW_FAST_MS * PBW_NS_PER_MS / PBW_CLK_PERIOD_NS;
  localparam int unsigned PBW_LONG_PRESS_CYCLES = PBW_LONG_PRESS_MS * PBW_NS_PER_MS / PBW_CLK_PERIOD_NS;
  localparam int unsigned PBW_PF_FILTER_CYCLES = 2;
  localparam int unsigned PBW_RECALL_CYCLES = 4;

  // ****************************************
  // Counter
  // ****************************************
  localparam int unsigned PBW_COUNT_W = 5;
  localparam int unsigned PBW_TAPS = 32;
  localparam logic [4:0] PBW_COUNT_RESET = 5'h00;
  localparam logic [4:0] PBW_COUNT_MAX = 5'h1f;
  localparam logic [4:0] PBW_COUNT_MIN = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic up;
    logic down;
    logic store;
  } pbw_buttons_type;

  typedef enum logic [1:0] {
    PBW_ST_RECALL = 2'b00,
    PBW_ST_IDLE = 2'b01,
    PBW_ST_HOLD = 2'b10
  } pbw_state_type;

endpackage
`default_nettype wire

// *** design/pbw_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbw_top
  import pbw_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = PBW_DEBOUNCE_CYCLES,
  parameter int unsigned SLOW_CYCLES = PBW_SLOW_CYCLES,
  parameter int unsigned FAST_CYCLES = PBW_FAST_CYCLES,
  parameter int unsigned LONG_PRESS_CYCLES = PBW_LONG_PRESS_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic step_up_n,
  input wire logic step_down_n,
  input wire logic store_enable_n,
  input wire logic power_fail,
  input wire logic [4:0] nv_read_data,
  output logic nv_write_en,
  output logic [4:0] nv_write_data,
  output logic [31:0] tap_select,
  output logic [4:0] wiper_position,
  output logic wiper_ready,
  output logic scan_fast
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] pbw_step(input logic [4:0] value, input logic up);
    logic [4:0] result;
    result = value;
    if (up && value != PBW_COUNT_MAX) begin
      result = value + 5'h01;
    end else if (!up && value != PBW_COUNT_MIN) begin
      result = value - 5'h01;
    end
    return result;
  endfunction

  function automatic logic [31:0] pbw_decode(input logic [4:0] value);
    return 32'h0000_0001 << value;
  endfunction

  // ****************************************
  // Input filtering
  // ****************************************
  pbw_buttons_type db;
  pbw_buttons_type sy;
  logic pf_db;

  pbw_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_db_up (
    .clock(clock),
    .rst_n(rst_n),
    .pin_n(step_up_n),
    .sync_level(sy.up),
    .stable_level(db.up)
  );

  pbw_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_db_down (
    .clock(clock),
    .rst_n(rst_n),
    .pin_n(step_down_n),
    .sync_level(sy.down),
    .stable_level(db.down)
  );

  pbw_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_db_store (
    .clock(clock),
    .rst_n(rst_n),
    .pin_n(store_enable_n),
    .sync_level(sy.store),
    .stable_level(db.store)
  );

  // Supply good level, falls on power fail
  pbw_debounce #(.CYCLES(PBW_PF_FILTER_CYCLES)) u_db_pf (
    .clock(clock),
    .rst_n(rst_n),
    .pin_n(~power_fail),
    .sync_level(),
    .stable_level(pf_db)
  );

  // ****************************************
  // State
  // ****************************************
  pbw_state_type state_reg;
  pbw_state_type state_next;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  logic [31:0] hold_reg;
  logic [31:0] hold_next;
  logic dir_up_reg;
  logic dir_up_next;
  logic fast_reg;
  logic fast_next;
  logic block_reg;
  logic block_next;
  logic manual_mode_reg;
  logic manual_mode_next;
  logic lock_reg;
  logic store_prev_reg;
  logic pf_prev_reg;
  logic ready_reg;
  logic nv_wr_reg;
  logic [4:0] nv_data_reg;
  logic [31:0] tap_reg;

  // ****************************************
  // Decode
  // ****************************************
  wire press_up_only = !db.up && db.down;
  wire press_down_only = db.up && !db.down;
  wire both_released = db.up && db.down;
  wire held_on = dir_up_reg ? (!sy.up && sy.down) : (sy.up && !sy.down);
  wire lock_set = manual_mode_reg && !db.store;
  wire manual_save = db.store && !store_prev_reg;
  wire auto_save = !pf_db && pf_prev_reg && !db.store;
  wire recall_done = timer_reg >= 32'(PBW_RECALL_CYCLES - 1);
  wire [31:0] step_period = fast_reg ? 32'(FAST_CYCLES) : 32'(SLOW_CYCLES);
  wire step_due = timer_reg >= step_period - 32'h0000_0001;
  wire long_press = hold_reg >= 32'(LONG_PRESS_CYCLES);

  // ****************************************
  // Step control
  // ****************************************
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    timer_next = timer_reg;
    hold_next = hold_reg;
    dir_up_next = dir_up_reg;
    fast_next = fast_reg;
    block_next = block_reg;
    manual_mode_next = manual_mode_reg;
    case (state_reg)
      PBW_ST_RECALL: begin
        timer_next = timer_reg + 32'h0000_0001;
        if (recall_done) begin
          count_next = nv_read_data;
          manual_mode_next = sy.store;
          timer_next = 32'h0000_0000;
          block_next = 1'b1;
          state_next = PBW_ST_IDLE;
        end
      end
      PBW_ST_IDLE: begin
        if (both_released) begin
          block_next = 1'b0;
        end
        if (!block_reg && !lock_reg && (press_up_only || press_down_only)) begin
          count_next = pbw_step(count_reg, press_up_only);
          dir_up_next = press_up_only;
          timer_next = 32'h0000_0000;
          hold_next = 32'h0000_0000;
          fast_next = 1'b0;
          state_next = PBW_ST_HOLD;
        end
      end
      PBW_ST_HOLD: begin
        if (!held_on || lock_reg) begin
          fast_next = 1'b0;
          block_next = 1'b1;
          state_next = PBW_ST_IDLE;
        end else begin
          timer_next = timer_reg + 32'h0000_0001;
          if (!long_press) begin
            hold_next = hold_reg + 32'h0000_0001;
          end else begin
            fast_next = 1'b1;
          end
          if (step_due) begin
            count_next = pbw_step(count_reg, dir_up_reg);
            timer_next = 32'h0000_0000;
          end
        end
      end
      default: begin
        state_next = PBW_ST_RECALL;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PBW_ST_RECALL;
      count_reg <= PBW_COUNT_RESET;
      timer_reg <= 32'h0000_0000;
      hold_reg <= 32'h0000_0000;
      dir_up_reg <= 1'b0;
      fast_reg <= 1'b0;
      block_reg <= 1'b1;
      manual_mode_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      timer_reg <= timer_next;
      hold_reg <= hold_next;
      dir_up_reg <= dir_up_next;
      fast_reg <= fast_next;
      block_reg <= block_next;
      manual_mode_reg <= manual_mode_next;
    end
  end

  // ****************************************
  // Store and lockout
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
      store_prev_reg <= 1'b1;
      pf_prev_reg <= 1'b1;
      nv_wr_reg <= 1'b0;
      nv_data_reg <= PBW_COUNT_RESET;
    end else begin
      lock_reg <= lock_set;
      store_prev_reg <= db.store;
      pf_prev_reg <= pf_db;
      nv_wr_reg <= ready_reg && (manual_save || auto_save);
      nv_data_reg <= count_reg;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tap_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
    end else begin
      tap_reg <= (state_next == PBW_ST_RECALL) ? 32'h0000_0000 : pbw_decode(count_next);
      ready_reg <= state_next != PBW_ST_RECALL;
    end
  end

  assign tap_select = tap_reg;
  assign wiper_position = count_reg;
  assign wiper_ready = ready_reg;
  assign scan_fast = fast_reg;
  assign nv_write_en = nv_wr_reg;
  assign nv_write_data = nv_data_reg;

endmodule // pbw_top
`default_nettype wire

// *** test/pbw_button_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbw_button_model
  import pbw_pkg::*;
(
  input wire pbw_buttons_type press,
  output logic step_up_n,
  output logic step_down_n,
  output logic store_enable_n
);
  // ******
  // Switches
  // ******
  // Open switch floats, pull-up reads high
  assign step_up_n = press.up ? 1'b0 : 1'b1;
  assign step_down_n = press.down ? 1'b0 : 1'b1;
  assign store_enable_n = press.store ? 1'b0 : 1'b1;
endmodule // pbw_button_model
`default_nettype wire

// *** test/pbw_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbw_top_checker
  import pbw_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic step_up_n,
  input wire logic step_down_n,
  input wire logic [4:0] nv_read_data,
  input wire logic nv_write_en,
  input wire logic [4:0] nv_write_data,
  input wire logic [31:0] tap_select,
  input wire logic [4:0] wiper_position,
  input wire logic wiper_ready,
  input wire logic scan_fast
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic [4:0] wp = wiper_position;
  // ******
  // Checks
  // ******
  AST_ONE_HOT: assert property (wiper_ready |-> $onehot(tap_select))
    else $error("tap select not one-hot");
  AST_DECODE: assert property (wiper_ready && $stable(wp) |-> tap_select == (32'h0000_0001 << wp))
    else $error("tap select not matching position");
  AST_STEP_ONE: assert property ($past(wiper_ready) && $changed(wp) |->
    {1'b0, wp} == {1'b0, $past(wp)} + 6'h01 || {1'b0, $past(wp)} == {1'b0, wp} + 6'h01)
    else $error("position moved by more than one");
  AST_DARK: assert property (!wiper_ready |-> tap_select == 32'h0000_0000 && !nv_write_en)
    else $error("activity before recall");
  AST_READY: assert property ($rose(rst_n) |-> ##[1:5] wiper_ready)
    else $error("recall late");
  AST_RECALL: assert property ($rose(wiper_ready) |-> wp == nv_read_data)
    else $error("recalled value wrong");
  AST_PULSE: assert property (nv_write_en |=> !nv_write_en)
    else $error("save pulse too long");
  AST_SAVE_DATA: assert property (nv_write_en |-> nv_write_data == $past(wp))
    else $error("saved value wrong");
  AST_BOTH_HELD: assert property ((!step_up_n && !step_down_n && wiper_ready) [*8] |=> $stable(wp))
    else $error("moved with both held");
  AST_RELEASE: assert property ((step_up_n && step_down_n && wiper_ready) [*5] |=> $stable(wp) && !scan_fast)
    else $error("stepping after release");
  COV_FAST: cover property ($rose(scan_fast));
  COV_SAVE: cover property (nv_write_en);
  COV_TOP: cover property (wiper_ready && wp == 5'h1f);
endmodule // pbw_top_checker
bind pbw_top pbw_top_checker i_pbw_top_checker (.clock(clock), .rst_n(rst_n), .step_up_n(step_up_n),
  .step_down_n(step_down_n), .nv_read_data(nv_read_data), .nv_write_en(nv_write_en),
  .nv_write_data(nv_write_data), .tap_select(tap_select), .wiper_position(wiper_position),
  .wiper_ready(wiper_ready), .scan_fast(scan_fast));
`default_nettype wire

// *** test/pbw_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("FAIL %s expected %0h seen %0h", what, exp, got); end end
module pbw_top_bench
  import pbw_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic power_fail = 1'b0;
  logic [4:0] nv_read_data = 5'h1e;
  pbw_buttons_type press = '0;
  wire logic step_up_n;
  wire logic step_down_n;
  wire logic store_enable_n;
  logic nv_write_en;
  logic [4:0] nv_write_data;
  logic [31:0] tap_select;
  logic [4:0] wiper_position;
  logic wiper_ready;
  logic scan_fast;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_save = 0;
  logic [4:0] saved = 5'h00;
  always #5 clock = ~clock;
  always @(posedge clock) if (nv_write_en === 1'b1) begin
    n_save <= n_save + 1;
    saved <= nv_write_data;
  end
  pbw_button_model i_pbw_button_model (.press(press), .step_up_n(step_up_n), .step_down_n(step_down_n),
    .store_enable_n(store_enable_n));
  pbw_top #(.DEBOUNCE_CYCLES(8), .SLOW_CYCLES(20), .FAST_CYCLES(6), .LONG_PRESS_CYCLES(60)) i_pbw_top (
    .clock(clock), .rst_n(rst_n), .step_up_n(step_up_n), .step_down_n(step_down_n),
    .store_enable_n(store_enable_n), .power_fail(power_fail), .nv_read_data(nv_read_data),
    .nv_write_en(nv_write_en), .nv_write_data(nv_write_data), .tap_select(tap_select),
    .wiper_position(wiper_position), .wiper_ready(wiper_ready), .scan_fast(scan_fast));
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset(input logic store_low);
    press = '0;
    press.store = store_low;
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    for (int i = 0; i < 20 && wiper_ready !== 1'b1; i++) cyc(1);
    `CHK("ready", 1'b1, wiper_ready)
    `CHK("recall", nv_read_data, wiper_position)
    if (wiper_ready !== 1'b1) give_verdict();
  endtask
  task automatic tap(input logic up, input logic dn, input int n);
    press.up = up;
    press.down = dn;
    cyc(n);
    press.up = 1'b0;
    press.down = 1'b0;
    cyc(20);
  endtask
  task automatic wait_step(output int n);
    logic [4:0] p;
    p = wiper_position;
    for (n = 0; n < 100 && wiper_position === p; n++) cyc(1);
    `CHK("step seen", 1'b1, n < 100)
    if (n >= 100) give_verdict();
  endtask
  task automatic t_steps();
    tap(1'b1, 1'b0, 4);
    `CHK("glitch", 5'h1e, wiper_position)
    tap(1'b1, 1'b0, 14);
    `CHK("up", 5'h1f, wiper_position)
    `CHK("tap", 32'h8000_0000, tap_select)
    tap(1'b1, 1'b0, 14);
    `CHK("top", 5'h1f, wiper_position)
    tap(1'b0, 1'b1, 14);
    `CHK("down", 5'h1e, wiper_position)
    tap(1'b1, 1'b1, 40);
    `CHK("both", 5'h1e, wiper_position)
  endtask
  task automatic t_hold();
    int g;
    int t;
    logic [4:0] p;
    press.down = 1'b1;
    wait_step(t);
    wait_step(g);
    `CHK("slow gap", 1'b1, g >= 19 && g <= 21)
    for (t = t + g; t < 200 && scan_fast !== 1'b1; t++) cyc(1);
    `CHK("fast time", 1'b1, t >= 66 && t <= 78)
    if (t >= 200) give_verdict();
    wait_step(g);
    wait_step(g);
    `CHK("fast gap", 1'b1, g >= 5 && g <= 7)
    press.down = 1'b0;
    cyc(6);
    `CHK("scan reset", 1'b0, scan_fast)
    p = wiper_position;
    cyc(20);
    `CHK("stopped", p, wiper_position)
  endtask
  task automatic t_store();
    logic [4:0] p;
    int s;
    p = wiper_position;
    s = n_save;
    press.store = 1'b1;
    cyc(14);
    tap(1'b1, 1'b0, 14);
    `CHK("locked", p, wiper_position)
    press.store = 1'b0;
    cyc(20);
    `CHK("manual save", s + 1, n_save)
    `CHK("manual data", p, saved)
  endtask
  task automatic t_auto();
    int s;
    tap(1'b1, 1'b0, 14);
    `CHK("auto step", 5'h04, wiper_position)
    s = n_save;
    power_fail = 1'b1;
    cyc(10);
    power_fail = 1'b0;
    `CHK("auto save", s + 1, n_save)
    `CHK("auto data", 5'h04, saved)
  endtask
  initial begin
    do_reset(1'b0);
    t_steps();
    t_hold();
    t_store();
    nv_read_data = 5'h03;
    do_reset(1'b1);
    t_auto();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
endmodule // pbw_top_bench
`default_nettype wire
